// ### design/spcc_ctrl.sv
// Socket supply requests and card clock power management over APB
//
// Chosen here: the APB slave port.
`timescale 1ns/1ns
module spcc_ctrl (
  input  wire logic                        clk,             // Host bus clock
  input  wire logic                        resetn,          // Sync reset, low
  input  wire logic                        psel,            // APB select
  input  wire logic                        penable,         // APB enable
  input  wire logic                        pwrite,          // APB direction
  input  wire logic [spcc_pkg::SPCC_AW-1:0] paddr,          // APB byte address
  input  wire logic [31:0]                 pwdata,          // APB write data
  output logic      [31:0]                 prdata,          // APB read data
  output logic                             pready,          // APB ready
  output logic                             pslverr,         // Unmapped address
  input  wire logic [spcc_pkg::SPCC_CAP_W-1:0] cardCapPin,  // Card voltage sense
  input  wire logic                        cardAccess,      // Card access pulse
  input  wire logic                        socketIdle,      // Socket idle level
  input  wire logic                        hostClkStopping, // Host clock stop prep
  output spcc_pkg::spcc_supply_t           supplyOut,       // Applied supplies
  output logic                             cardClkTick,     // Card clock enable
  output logic                             irq              // Interrupt level
);
  import spcc_pkg::*;

  // ==========================================================
  // Supply check, used for both supplies
  function automatic logic supplyOk(input logic [2:0] code,
                                    input logic [SPCC_CAP_W-1:0] cap,
                                    input logic isVpp);
    logic ok;
    ok = 1'b0;
    case (code)
      SPCC_SUP_OFF: ok = 1'b1;
      SPCC_VPP_12V: ok = isVpp & (|cap);
      SPCC_SUP_5V:  ok = cap[SPCC_CAP_5V];
      SPCC_SUP_3V3: ok = cap[SPCC_CAP_3V];
      SPCC_SUP_X:   ok = cap[SPCC_CAP_X];
      SPCC_SUP_Y:   ok = cap[SPCC_CAP_Y];
      default:      ok = 1'b0;
    endcase
    return ok;
  endfunction : supplyOk

  // ==========================================================
  // Sense pin synchroniser
  // Pins are asynchronous to the host clock
  logic [SPCC_CAP_W-1:0] capMeta_reg;
  logic [SPCC_CAP_W-1:0] capSync_reg;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      capMeta_reg <= '0;
      capSync_reg <= '0;
    end else begin
      capMeta_reg <= cardCapPin;
      capSync_reg <= capMeta_reg;
    end
  end

  // ==========================================================
  // APB decode
  logic        setupPh;
  logic        accessDone;
  logic        wrDone;
  logic        rdDone;
  logic        hitForce;
  logic        hitCtrl;
  logic        hitPm;
  logic        hitIrqSt;
  logic        hitIrqMsk;
  logic        hitAny;
  logic        wrForce;
  logic        wrCtrl;
  logic        wrPm;
  logic        wrIrqSt;
  logic        wrIrqMsk;
  logic        rdPm;

  assign setupPh    = psel & ~penable;
  assign accessDone = psel & penable & pready;
  assign wrDone     = accessDone & pwrite;
  assign rdDone     = accessDone & ~pwrite;
  assign hitForce   = paddr == SPCC_OFF_FORCE;
  assign hitCtrl    = paddr == SPCC_OFF_CTRL;
  assign hitPm      = paddr == SPCC_OFF_PM;
  assign hitIrqSt   = paddr == SPCC_OFF_IRQST;
  assign hitIrqMsk  = paddr == SPCC_OFF_IRQMSK;
  assign hitAny     = hitForce | hitCtrl | hitPm | hitIrqSt | hitIrqMsk;
  assign wrForce    = wrDone & hitForce;
  assign wrCtrl     = wrDone & hitCtrl;
  assign wrPm       = wrDone & hitPm;
  assign wrIrqSt    = wrDone & hitIrqSt;
  assign wrIrqMsk   = wrDone & hitIrqMsk;
  assign rdPm       = rdDone & hitPm;

  // ==========================================================
  // Register state
  logic                  policy_reg;
  logic [2:0]            vccReq_reg;
  logic [2:0]            vppReq_reg;
  logic                  clock_control_enable_reg;
  logic                  stopSlowSel_reg;
  logic                  accessSeen_reg;
  logic                  accessSeen_next;
  logic [SPCC_CAP_W-1:0] cardCap_reg;
  logic [SPCC_CAP_W-1:0] cardCap_next;
  logic                  ctrlEnabled_reg;
  logic                  ctrlEnabled_next;
  logic [SPCC_IRQ_W-1:0] irqSt_reg;
  logic [SPCC_IRQ_W-1:0] irqSt_next;
  logic [SPCC_IRQ_W-1:0] irqMsk_reg;
  logic [SPCC_IRQ_W-1:0] irqEvent;
  spcc_clk_state_t       clkState_reg;
  spcc_clk_state_t       clkState_next;
  logic [SPCC_DIV_W-1:0] divCnt_reg;

  // ==========================================================
  // Supply request acceptance
  logic [2:0] vccWr;
  logic [2:0] vppWr;
  logic       reqOk;
  logic       reqRefused;
  logic       forceAny;
  logic       wrAccept;

  assign vccWr      = pwdata[SPCC_VCC_LSB +: 3];
  assign vppWr      = pwdata[SPCC_VPP_LSB +: 3];
  assign reqOk      = ctrlEnabled_reg
                    & supplyOk(vccWr, cardCap_reg, 1'b0)
                    & supplyOk(vppWr, cardCap_reg, 1'b1);
  assign reqRefused = wrCtrl & ~reqOk;
  assign forceAny   = |pwdata[SPCC_FCAP_LSB +: SPCC_CAP_W];
  assign wrAccept   = wrCtrl & reqOk;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      policy_reg <= 1'b0;
      vccReq_reg <= SPCC_SUP_OFF;
      vppReq_reg <= SPCC_SUP_OFF;
    end else if (wrCtrl) begin
      policy_reg <= pwdata[SPCC_POLICY_BIT];
      if (wrAccept) begin
        vccReq_reg <= vccWr;
        vppReq_reg <= vppWr;
      end
    end
  end

  // ==========================================================
  // Capability and control enable, driven by force writes
  // Retest wins over a forced capability in one write
  always_comb begin
    cardCap_next     = cardCap_reg;
    ctrlEnabled_next = ctrlEnabled_reg;
    if (wrForce && pwdata[SPCC_RETEST_BIT]) begin
      cardCap_next     = capSync_reg;
      ctrlEnabled_next = 1'b1;
    end else if (wrForce && forceAny) begin
      cardCap_next     = cardCap_reg | pwdata[SPCC_FCAP_LSB +: SPCC_CAP_W];
      ctrlEnabled_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cardCap_reg     <= '0;
      ctrlEnabled_reg <= 1'b0;
    end else begin
      cardCap_reg     <= cardCap_next;
      ctrlEnabled_reg <= ctrlEnabled_next;
    end
  end

  // ==========================================================
  // Power management register
  // Only bits shown as set in the read clear, so a set between
  // capture and completion survives
  assign accessSeen_next = cardAccess
                         | (accessSeen_reg & ~(rdPm & prdata[SPCC_ACCESS_BIT]));

  always_ff @(posedge clk) begin
    if (!resetn) begin
      clock_control_enable_reg   <= 1'b0;
      stopSlowSel_reg <= 1'b0;
      accessSeen_reg  <= 1'b0;
    end else begin
      accessSeen_reg <= accessSeen_next;
      if (wrPm) begin
        clock_control_enable_reg   <= pwdata[SPCC_EN_BIT];
        stopSlowSel_reg <= pwdata[SPCC_SEL_BIT];
      end
    end
  end

  // ==========================================================
  // Card clock control
  logic                  allowIdle;
  logic                  divLast;
  logic                  inRun;
  logic                  inSlow;
  logic [SPCC_DIV_W-1:0] divCnt_next;
  logic                  clkTick_next;

  assign allowIdle    = clock_control_enable_reg
                      & socketIdle
                      & (policy_reg | hostClkStopping);
  assign inRun        = clkState_reg == SPCC_CLK_RUN;
  assign inSlow       = clkState_reg == SPCC_CLK_SLOW;
  assign divLast      = divCnt_reg == SPCC_DIV_LAST;
  assign divCnt_next  = inSlow ? divCnt_reg + 1'b1 : '0;
  assign clkTick_next = inRun | (inSlow & divLast);

  // Idle target picked by the stop-or-slow select
  function automatic spcc_clk_state_t idleState(input logic sel);
    return sel ? SPCC_CLK_SLOW : SPCC_CLK_STOP;
  endfunction : idleState

  always_comb begin
    case (clkState_reg)
      SPCC_CLK_RUN: begin
        clkState_next = allowIdle ? idleState(stopSlowSel_reg) : SPCC_CLK_RUN;
      end
      SPCC_CLK_SLOW: begin
        // Select may change while slowed; follow it at once
        clkState_next = allowIdle ? idleState(stopSlowSel_reg) : SPCC_CLK_RUN;
      end
      SPCC_CLK_STOP: begin
        clkState_next = allowIdle ? idleState(stopSlowSel_reg) : SPCC_CLK_RUN;
      end
      default: begin
        clkState_next = SPCC_CLK_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      clkState_reg <= SPCC_CLK_RUN;
      divCnt_reg   <= '0;
      cardClkTick  <= 1'b0;
    end else begin
      clkState_reg <= clkState_next;
      divCnt_reg   <= divCnt_next;
      cardClkTick  <= clkTick_next;
    end
  end

  logic modeChanged;
  assign modeChanged = clkState_reg != SPCC_CLK_RUN;

  // ==========================================================
  // Interrupt status, write one to clear, set wins
  // Mode event fires on every clock state change
  assign irqEvent[SPCC_IRQ_ACCESS] = cardAccess;
  assign irqEvent[SPCC_IRQ_REFUSE] = reqRefused;
  assign irqEvent[SPCC_IRQ_MODE]   = clkState_next != clkState_reg;

  genvar gi;
  generate
    for (gi = 0; gi < SPCC_IRQ_W; gi++) begin : gIrq
      assign irqSt_next[gi] = irqEvent[gi] | (irqSt_reg[gi] & ~(wrIrqSt & pwdata[gi]));
      always_ff @(posedge clk) begin
        if (!resetn) begin
          irqSt_reg[gi] <= 1'b0;
        end else begin
          irqSt_reg[gi] <= irqSt_next[gi];
        end
      end
    end
  endgenerate

  logic irqPending;
  assign irqPending = |(irqSt_reg & irqMsk_reg);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      irqMsk_reg <= '0;
      irq        <= 1'b0;
    end else begin
      if (wrIrqMsk) begin
        irqMsk_reg <= pwdata[SPCC_IRQ_W-1:0];
      end
      irq <= irqPending;
    end
  end

  // ==========================================================
  // Read mux; reserved bits stay zero
  logic [31:0] ctrlRd;
  logic [31:0] pmRd;
  logic [31:0] rdValue;

  always_comb begin
    ctrlRd                          = SPCC_RESET_VAL;
    ctrlRd[SPCC_POLICY_BIT]         = policy_reg;
    ctrlRd[SPCC_VCC_LSB +: 3]       = vccReq_reg;
    ctrlRd[SPCC_VPP_LSB +: 3]       = vppReq_reg;
    pmRd                            = SPCC_RESET_VAL;
    pmRd[SPCC_ACCESS_BIT]           = accessSeen_reg;
    pmRd[SPCC_MODE_BIT]             = modeChanged;
    pmRd[SPCC_EN_BIT]               = clock_control_enable_reg;
    pmRd[SPCC_SEL_BIT]              = stopSlowSel_reg;
  end

  assign rdValue = hitCtrl   ? ctrlRd :
                   hitPm     ? pmRd :
                   hitIrqSt  ? {{(32-SPCC_IRQ_W){1'b0}}, irqSt_reg} :
                   hitIrqMsk ? {{(32-SPCC_IRQ_W){1'b0}}, irqMsk_reg} :
                   SPCC_RESET_VAL;

  logic [31:0] rdReturn;
  assign rdReturn = pwrite ? SPCC_RESET_VAL : rdValue;

  // ==========================================================
  // APB answer: ready in the first access cycle
  // Read data taken at setup, ahead of any read-clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= SPCC_RESET_VAL;
    end else if (setupPh) begin
      pready  <= 1'b1;
      pslverr <= ~hitAny;
      prdata  <= rdReturn;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ==========================================================
  // Applied supplies follow accepted requests
  // Refused writes never reach the power switch
  always_ff @(posedge clk) begin
    if (!resetn) begin
      supplyOut <= '0;
    end else begin
      supplyOut.vcc <= vccReq_reg;
      supplyOut.vpp <= vppReq_reg;
    end
  end

endmodule : spcc_ctrl

// ### inc/spcc_pkg.sv
// Constants and types for the socket supply and card clock control block
// Functional notes
// - Policy 0: idle and host clock stopping
// - Policy 1: stop or slow whenever idle
// - Card supply codes; 001,110,111 reserved
// - Program supply codes 000 to 011
// - Program supply 100,101 extra; 110,111 reserved
// - Control bits 31-8 and 3 read zero
// - Refuse supply not matching detected card
// - Access flag set on access, read clears
// - Mode bit shows clock changed
// - Select works only while enable set
// - Select 0 stops clock when idle
// - Select 1 divides clock by 16
// - Power management reserved bits read zero
// - Clock slowed or stopped only when idle
// - Retest reloads capability, re-enables control
// - Forced capability disables control until retest
package spcc_pkg;

  // ==========================================================
  // Register map
  localparam int          SPCC_AW          = 8;
  localparam logic [7:0]  SPCC_OFF_FORCE   = 8'h0c;
  localparam logic [7:0]  SPCC_OFF_CTRL    = 8'h10;
  localparam logic [7:0]  SPCC_OFF_PM      = 8'h20;
  localparam logic [7:0]  SPCC_OFF_IRQST   = 8'h30;
  localparam logic [7:0]  SPCC_OFF_IRQMSK  = 8'h34;
  localparam logic [31:0] SPCC_RESET_VAL   = 32'h0000_0000;

  // ==========================================================
  // Field positions
  localparam int SPCC_POLICY_BIT = 7;
  localparam int SPCC_VCC_LSB    = 4;
  localparam int SPCC_VPP_LSB    = 0;
  localparam int SPCC_ACCESS_BIT = 25;
  localparam int SPCC_MODE_BIT   = 24;
  localparam int SPCC_EN_BIT     = 16;
  localparam int SPCC_SEL_BIT    = 0;
  localparam int SPCC_RETEST_BIT = 14;
  localparam int SPCC_FCAP_LSB   = 10;
  localparam int SPCC_CAP_W      = 4;
  localparam int SPCC_CAP_5V     = 0;
  localparam int SPCC_CAP_3V     = 1;
  localparam int SPCC_CAP_X      = 2;
  localparam int SPCC_CAP_Y      = 3;
  localparam int SPCC_IRQ_W      = 3;
  localparam int SPCC_IRQ_ACCESS = 0;
  localparam int SPCC_IRQ_REFUSE = 1;
  localparam int SPCC_IRQ_MODE   = 2;

  // ==========================================================
  // Supply request codes
  localparam logic [2:0] SPCC_SUP_OFF = 3'h0;
  localparam logic [2:0] SPCC_VPP_12V = 3'h1;
  localparam logic [2:0] SPCC_SUP_5V  = 3'h2;
  localparam logic [2:0] SPCC_SUP_3V3 = 3'h3;
  localparam logic [2:0] SPCC_SUP_X   = 3'h4;
  localparam logic [2:0] SPCC_SUP_Y   = 3'h5;

  // ==========================================================
  // Card clock slow-down
  localparam int         SPCC_SLOW_DIV = 16;
  localparam int         SPCC_DIV_W    = 4;
  localparam logic [3:0] SPCC_DIV_LAST = 4'(SPCC_SLOW_DIV - 1);

  typedef enum logic [2:0] {
    SPCC_CLK_RUN  = 3'b001,
    SPCC_CLK_SLOW = 3'b010,
    SPCC_CLK_STOP = 3'b100
  } spcc_clk_state_t;

  typedef struct packed {
    logic [2:0] vcc;
    logic [2:0] vpp;
  } spcc_supply_t;

endpackage : spcc_pkg

// ### test/spcc_card_model.sv
// Card and socket model facing the control block
`timescale 1ns/1ns
module spcc_card_model (
  input  wire logic       clk,             // Host clock
  input  wire logic [3:0] capSet,          // Card voltage set
  input  wire logic       hostStop,        // Host stop request
  input  wire logic       accessReq,       // Start card access
  output logic      [3:0] cardCapPin,      // Sense pins
  output logic            cardAccess,      // Access pulse
  output logic            socketIdle,      // Idle level
  output logic            hostClkStopping  // Host stop level
);
  logic [1:0] busyCnt = 2'h0;
  assign cardCapPin      = capSet;
  assign hostClkStopping = hostStop;
  // Socket stays busy a few cycles per access
  assign socketIdle      = (busyCnt == 2'h0);
  always @(posedge clk) begin
    cardAccess <= accessReq;
    busyCnt    <= accessReq ? 2'h3 : busyCnt - {1'b0, busyCnt != 2'h0};
  end
endmodule : spcc_card_model

// ### test/spcc_ctrl_chk.sv
// Port assertions for the supply and clock control block
`timescale 1ns/1ns
module spcc_ctrl_chk (
  input wire logic                            clk,             // Clock
  input wire logic                            resetn,          // Reset, low
  input wire logic                            psel,            // APB select
  input wire logic                            penable,         // APB enable
  input wire logic                            pwrite,          // APB direction
  input wire logic [spcc_pkg::SPCC_AW-1:0]    paddr,           // APB address
  input wire logic [31:0]                     pwdata,          // Write data
  input wire logic [31:0]                     prdata,          // Read data
  input wire logic                            pready,          // Ready
  input wire logic                            pslverr,         // Error
  input wire logic [spcc_pkg::SPCC_CAP_W-1:0] cardCapPin,      // Sense pins
  input wire logic                            cardAccess,      // Access pulse
  input wire logic                            socketIdle,      // Idle level
  input wire logic                            hostClkStopping, // Host stop
  input wire spcc_pkg::spcc_supply_t          supplyOut,       // Supplies
  input wire logic                            cardClkTick,     // Card clock
  input wire logic                            irq              // Interrupt
);
  import spcc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // Sequences and properties
  sequence s_setup; psel && !penable; endsequence
  sequence s_busy; !socketIdle [*3]; endsequence
  sequence s_rd(a); pready && !pwrite && paddr == a; endsequence
  property p_answer; s_setup |=> pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready && (pwrite || prdata == 32'h0); endproperty
  property p_ctrlZero; s_rd(SPCC_OFF_CTRL) |-> (prdata & 32'hffff_ff08) == 32'h0; endproperty
  property p_pmZero; s_rd(SPCC_OFF_PM) |-> (prdata & 32'hfcfe_fffe) == 32'h0; endproperty
  property p_busyRun; s_busy |=> cardClkTick; endproperty
  property p_supHold; !(psel && penable && pwrite) [*2] |=> $stable(supplyOut); endproperty
  property p_codes; supplyOut.vcc inside {3'h0, [3'h2:3'h5]} && supplyOut.vpp <= 3'h5; endproperty
  property p_idleGate; $past(resetn, 1) && $past(resetn, 2) && !cardClkTick |-> $past(socketIdle, 2); endproperty
  // ==========================================================
  // Assertions
  a_answer: assert property (p_answer) else $error("no ready after setup");
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  a_err: assert property (p_err) else $error("bad error response");
  a_ctrlZero: assert property (p_ctrlZero) else $error("control reserved bits set");
  a_pmZero: assert property (p_pmZero) else $error("power reserved bits set");
  a_busyRun: assert property (p_busyRun) else $error("clock held while busy");
  a_supHold: assert property (p_supHold) else $error("supply moved without write");
  a_codes: assert property (p_codes) else $error("reserved supply code applied");
  a_idleGate: assert property (p_idleGate) else $error("card clock held while socket busy");
endmodule : spcc_ctrl_chk
bind spcc_ctrl spcc_ctrl_chk u_chk (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .cardCapPin, .cardAccess, .socketIdle, .hostClkStopping, .supplyOut, .cardClkTick, .irq);

// ### test/tb.sv
// Self-checking bench for the supply and clock control block
`timescale 1ns/1ns
module tb;
  import spcc_pkg::*;
  logic         clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]   paddr = 0;
  logic [31:0]  pwdata = 0, prdata, ctl, pw;
  logic         pready, pslverr, cardClkTick, irq, hostStop = 0, accessReq = 0;
  logic [3:0]   capSet = 0, cardCapPin;
  logic         cardAccess, socketIdle, hostClkStopping;
  spcc_supply_t supplyOut;
  logic [32:0]  expQ[$];
  int           err_count = 0, checked = 0;
  always #5 clk = ~clk;
  spcc_ctrl dut (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .cardCapPin, .cardAccess, .socketIdle, .hostClkStopping, .supplyOut, .cardClkTick, .irq);
  spcc_card_model card (.clk, .capSet, .hostStop, .accessReq, .cardCapPin, .cardAccess, .socketIdle,
    .hostClkStopping);
  // ==========================================================
  // Tasks
  task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      chk(0, 1, "apb timeout");
      give_verdict();
    end
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    expQ.push_back(e);
    apb(0, a, 0);
  endtask : rd
  task automatic ticks(input int n, input int e, input string m);
    int c;
    c = 0;
    repeat (3) @(posedge clk);
    repeat (n) begin
      @(posedge clk);
      c += int'(cardClkTick === 1'b1);
    end
    chk(33'(c), 33'(e), m);
  endtask : ticks
  // ==========================================================
  // Read monitor
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0) chk({pslverr, prdata}, expQ.pop_front(), "read");
  end
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'hf0659902));
    repeat (4) @(posedge clk);
    resetn <= 1;
    @(posedge clk);
    rd(SPCC_OFF_CTRL, 0);
    rd(SPCC_OFF_PM, 0);
    $display("test reset done");
    capSet <= 4'h1;
    repeat (3) @(posedge clk);
    apb(1, SPCC_OFF_CTRL, 32'h20);
    rd(SPCC_OFF_CTRL, 0);
    apb(1, SPCC_OFF_FORCE, 32'h4000);
    ctl = 32'ha2;
    apb(1, SPCC_OFF_CTRL, ($urandom() & 32'hffff_ff08) | ctl);
    rd(SPCC_OFF_CTRL, {1'b0, ctl});
    for (int i = 0; i < 16; i++) begin
      pw = 32'h80 | (32'(i % 8) << (i < 8 ? 0 : 4));
      if (i % 8 == 0 || i % 8 == 2 || i == 1) ctl = pw;
      apb(1, SPCC_OFF_CTRL, pw);
      rd(SPCC_OFF_CTRL, {1'b0, ctl});
    end
    apb(1, SPCC_OFF_CTRL, 32'ha2);
    @(posedge clk);
    chk({27'h0, supplyOut}, 33'h12, "supply");
    apb(1, SPCC_OFF_FORCE, 32'h400);
    apb(1, SPCC_OFF_CTRL, 32'h80);
    rd(SPCC_OFF_CTRL, 33'ha2);
    apb(1, SPCC_OFF_FORCE, 32'h4000);
    $display("test supply done");
    chk({32'h0, irq}, 0, "irq masked");
    apb(1, SPCC_OFF_IRQMSK, 32'h2);
    @(posedge clk);
    chk({32'h0, irq}, 1, "irq up");
    rd(SPCC_OFF_IRQST, 33'h2);
    apb(1, SPCC_OFF_IRQST, 32'h2);
    @(posedge clk);
    chk({32'h0, irq}, 0, "irq clear");
    rd(8'h40, {1'b1, 32'h0});
    $display("test irq done");
    accessReq <= 1;
    @(posedge clk);
    accessReq <= 0;
    repeat (4) @(posedge clk);
    rd(SPCC_OFF_PM, 33'h0200_0000);
    rd(SPCC_OFF_PM, 0);
    $display("test access done");
    apb(1, SPCC_OFF_PM, 32'h1_0000);
    ticks(8, 0, "stopped");
    rd(SPCC_OFF_PM, 33'h0101_0000);
    apb(1, SPCC_OFF_CTRL, 32'h22);
    ticks(8, 8, "policy wait");
    hostStop <= 1;
    ticks(8, 0, "host stop");
    accessReq <= 1;
    @(posedge clk);
    accessReq <= 0;
    ticks(8, 2, "busy runs");
    apb(1, SPCC_OFF_PM, 32'h1_0001);
    ticks(32, 2, "slowed");
    apb(1, SPCC_OFF_PM, 32'h1);
    ticks(16, 16, "disabled");
    $display("test clock done");
    give_verdict();
  end
endmodule : tb
